// ===== sfrd_pkg.sv
// sfrd_pkg: shared constants and types for the register space decoder
package sfrd_pkg;
    // ******************************
    // address map
    // ******************************
    localparam logic [7:0] SFRD_SFR_BASE    = 8'h80;
    localparam logic [7:0] SFRD_ADDR_PORT0  = 8'h80;
    localparam logic [7:0] SFRD_ADDR_SP     = 8'h81;
    localparam logic [7:0] SFRD_ADDR_DATA_POINTER0_LOW   = 8'h82;
    localparam logic [7:0] SFRD_ADDR_DATA_POINTER0_HIGH   = 8'h83;
    localparam logic [7:0] SFRD_ADDR_PORT1  = 8'h90;
    localparam logic [7:0] SFRD_ADDR_SBUF   = 8'h99;
    localparam logic [7:0] SFRD_ADDR_PORT2  = 8'ha0;
    localparam logic [7:0] SFRD_ADDR_PORT3  = 8'hb0;
    localparam logic [7:0] SFRD_BIT_RAM_BASE = 8'h20;
    // ******************************
    // reset values
    // ******************************
    localparam logic [7:0] SFRD_SP_RESET    = 8'h07;
    localparam logic [7:0] SFRD_PORT_RESET  = 8'hff;
    localparam logic [7:0] SFRD_ZERO8       = 8'h00;
    localparam logic [15:0] SFRD_ZERO16     = 16'h0000;
    localparam logic [7:0] SFRD_ONE8        = 8'h01;
    localparam logic [15:0] SFRD_ONE16      = 16'h0001;
    localparam int         SFRD_RAM_DEPTH   = 128;
    localparam int         SFRD_NPORTS      = 4;
    // ******************************
    // bus operation codes
    // ******************************
    typedef enum logic [2:0] {
        SFRD_OP_NONE  = 3'h0,
        SFRD_OP_READ  = 3'h1,
        SFRD_OP_WRITE = 3'h2,
        SFRD_OP_BSET  = 3'h3,
        SFRD_OP_BCLR  = 3'h4
    } sfrd_op_t;
    typedef enum logic [2:0] {
        SFRD_SP_HOLD = 3'h0,
        SFRD_SP_PUSH = 3'h1,
        SFRD_SP_POP  = 3'h2,
        SFRD_SP_CALL = 3'h3,
        SFRD_SP_RET  = 3'h4
    } sfrd_spop_t;

    // 24 unassigned locations of the 128 in register space
    function automatic logic sfrd_assigned(input logic [7:0] a);
        logic [127:0] map;
        map = 128'hffc7_ffff_ffff_3d43_011f_ffef_ff3f_ffff;
        return map[a[6:0]];
    endfunction
endpackage

// ===== sfrd_bus_if.sv
// sfrd_bus_if: internal bit-level access bundle
`timescale 1ns/100ps
interface sfrd_bus_if;
    logic [7:0] bit_addr;
    logic       bit_rd;
    logic       bit_hit;
    logic [7:0] bit_byte_addr;
    logic [2:0] bit_index;
    modport decoder (input bit_addr, input bit_rd, output bit_hit,
                     output bit_byte_addr, output bit_index);
    modport user (output bit_addr, output bit_rd, input bit_hit,
                  input bit_byte_addr, input bit_index);
endinterface

// ===== sfrd_bit_decode.sv
// sfrd_bit_decode: bit address to byte address and bit index
`timescale 1ns/100ps
module sfrd_bit_decode
    import sfrd_pkg::*;
(
    sfrd_bus_if.decoder bus
);
    always_comb begin
        if (bus.bit_addr[7]) begin
            // register space: only addresses divisible by eight
            bus.bit_byte_addr = {bus.bit_addr[7:3], 3'h0};
        end else begin
            // ram bits: eight per byte, sixteen bytes from the base
            bus.bit_byte_addr = SFRD_BIT_RAM_BASE + 8'(bus.bit_addr[6:3]);
        end
        bus.bit_index = bus.bit_addr[2:0];
        bus.bit_hit   = bus.bit_rd;
    end
endmodule // sfrd_bit_decode

// ===== sfrd_space_decoder.sv
// sfrd_space_decoder: direct address space, core registers and ports
// ******************************
// Behaviour
// - direct addresses 00-7F go to internal RAM, 80-FF to registers
// - 24 register-space addresses hold no register
// - unassigned addresses read zero, writes ignored
// - registers at multiples of eight accept bit set and clear
// - other registers are not bit reachable
// - bit 0 is least significant, bit 7 most
// - a write to 99h loads the serial buffer
// - port 0 latch bits drive matching pins high or low
// - external memory mode takes ports 0 and 2 for addressing
// - stack pointer shows top byte; push writes at pointer plus one
// - every stack-altering operation updates the stack pointer
// - stack pointer resets to 07h, first push lands at 08h
// - data pointer 0 low and high form one 16-bit pointer
// - four 8-bit port registers give 32 lines, read back pins
// ******************************
`timescale 1ns/100ps
module sfrd_space_decoder
    import sfrd_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire sfrd_op_t   op,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire sfrd_spop_t sp_op,
    input  wire logic [7:0] sp_data,
    input  wire logic       dptr_inc,
    input  wire logic       ext_mem_mode,
    input  wire logic [15:0] ext_addr,
    input  wire logic [31:0] port_pin_in,
    output logic [7:0]      rdata,
    output logic            rbit,
    output logic            rvalid,
    output logic [31:0]     port_pin_out,
    output logic [7:0]      stack_addr,
    output logic [7:0]      stack_wdata,
    output logic            stack_we,
    output logic [15:0]     data_pointer0,
    output logic [7:0]      serial_buffer_primary,
    output logic            serial_load
);
    // ******************************
    // state
    // ******************************
    logic [7:0]  ram_mem [SFRD_RAM_DEPTH];
    logic [7:0]  port_latch_reg [SFRD_NPORTS];
    logic [7:0]  port_latch_next [SFRD_NPORTS];
    logic [7:0]  stack_pointer_reg, stack_pointer_next;
    logic [15:0] dptr_reg, dptr_next;
    logic [7:0]  sbuf_reg, sbuf_next;
    logic        sload_reg, sload_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        rbit_reg, rbit_next;
    logic        rvalid_reg, rvalid_next;
    logic [7:0]  saddr_reg, saddr_next;
    logic [7:0]  swd_reg, swd_next;
    logic        swe_reg, swe_next;
    logic [31:0] pin_out_reg, pin_out_next;
    logic [31:0] pin_s1_reg, pin_s2_reg;
    logic        ext_s1_reg, ext_s2_reg;

    logic        is_bitop, ram_we;
    logic [7:0]  byte_addr, ram_wval, cur, newval, bit_src;
    logic [2:0]  bidx;

    sfrd_bus_if bbus();
    assign bbus.bit_addr = addr;
    assign bbus.bit_rd   = is_bitop;
    assign is_bitop      = (op == SFRD_OP_BSET) || (op == SFRD_OP_BCLR);
    sfrd_bit_decode sfrd_bit_decode_i (.bus(bbus));

    function automatic int port_index(input logic [7:0] a);
        unique case (a)
            SFRD_ADDR_PORT0: return 0;
            SFRD_ADDR_PORT1: return 1;
            SFRD_ADDR_PORT2: return 2;
            SFRD_ADDR_PORT3: return 3;
            default:         return -1;
        endcase
    endfunction

    // pins enter through two flops before any logic reads them
    always_ff @(posedge sys_clk) begin
        pin_s1_reg   <= port_pin_in;
        pin_s2_reg   <= pin_s1_reg;
        ext_s1_reg   <= ext_mem_mode;
        ext_s2_reg   <= ext_s1_reg;
    end

    // current byte at the target address
    function automatic logic [7:0] read_byte(input logic [7:0] a);
        logic [7:0] v;
        v = SFRD_ZERO8;
        if (!a[7]) begin
            v = ram_mem[a[6:0]];
        end else if (!sfrd_assigned(a)) begin
            v = SFRD_ZERO8;
        end else if (port_index(a) >= 0) begin
            v = pin_s2_reg[port_index(a)*8 +: 8];
        end else begin
            unique case (a)
                SFRD_ADDR_SP:   v = stack_pointer_reg;
                SFRD_ADDR_DATA_POINTER0_LOW: v = dptr_reg[7:0];
                SFRD_ADDR_DATA_POINTER0_HIGH: v = dptr_reg[15:8];
                SFRD_ADDR_SBUF: v = sbuf_reg;
                default:        v = SFRD_ZERO8;
            endcase
        end
        return v;
    endfunction

    // ******************************
    // next-state logic
    // ******************************
    always_comb begin
        byte_addr = bbus.bit_hit ? bbus.bit_byte_addr : addr;
        bidx      = bbus.bit_index;
        bit_src   = read_byte(bbus.bit_byte_addr);
        cur       = read_byte(byte_addr);
        if (byte_addr[7] && port_index(byte_addr) >= 0) begin
            // bit ops on ports modify the latch, not the pin value
            cur = port_latch_reg[port_index(byte_addr)];
        end
        newval = cur;
        if (op == SFRD_OP_BSET) begin
            newval[bidx] = 1'b1;
        end else if (op == SFRD_OP_BCLR) begin
            newval[bidx] = 1'b0;
        end else begin
            newval = wdata;
        end
        for (int i = 0; i < SFRD_NPORTS; i++) begin
            port_latch_next[i] = port_latch_reg[i];
        end
        stack_pointer_next = stack_pointer_reg;
        dptr_next          = dptr_reg;
        sbuf_next          = sbuf_reg;
        sload_next         = 1'b0;
        ram_we             = 1'b0;
        ram_wval           = newval;
        swe_next           = 1'b0;
        saddr_next         = saddr_reg;
        swd_next           = swd_reg;
        rvalid_next        = (op == SFRD_OP_READ);
        rdata_next         = rdata_reg;
        rbit_next          = rbit_reg;
        if (op == SFRD_OP_READ) begin
            rdata_next = read_byte(addr);
            rbit_next  = bit_src[bidx];
        end
        if (op == SFRD_OP_WRITE || is_bitop) begin
            if (!byte_addr[7]) begin
                ram_we = 1'b1;
            end else if (sfrd_assigned(byte_addr)) begin
                if (port_index(byte_addr) >= 0) begin
                    port_latch_next[port_index(byte_addr)] = newval;
                end else begin
                    unique case (byte_addr)
                        SFRD_ADDR_SP:   stack_pointer_next = newval;
                        SFRD_ADDR_DATA_POINTER0_LOW: dptr_next[7:0]     = newval;
                        SFRD_ADDR_DATA_POINTER0_HIGH: dptr_next[15:8]    = newval;
                        SFRD_ADDR_SBUF: begin
                            sbuf_next  = newval;
                            sload_next = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
        end
        if (dptr_inc) begin
            dptr_next = dptr_reg + SFRD_ONE16;
        end
        // stack operations from the core
        unique case (sp_op)
            SFRD_SP_PUSH, SFRD_SP_CALL: begin
                stack_pointer_next = stack_pointer_reg + SFRD_ONE8;
                saddr_next         = stack_pointer_reg + SFRD_ONE8;
                swd_next           = sp_data;
                swe_next           = 1'b1;
            end
            SFRD_SP_POP, SFRD_SP_RET: begin
                stack_pointer_next = stack_pointer_reg - SFRD_ONE8;
            end
            default: ;
        endcase
        // external memory mode: ports 0 and 2 carry the address
        for (int i = 0; i < SFRD_NPORTS; i++) begin
            pin_out_next[i*8 +: 8] = port_latch_next[i];
        end
        // address word comes from the core on this clock: no synchroniser
        if (ext_s2_reg) begin
            pin_out_next[7:0]   = ext_addr[7:0];
            pin_out_next[23:16] = ext_addr[15:8];
        end
    end

    // ******************************
    // registers
    // ******************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < SFRD_NPORTS; i++) begin
                port_latch_reg[i] <= SFRD_PORT_RESET;
            end
            stack_pointer_reg <= SFRD_SP_RESET;
            dptr_reg          <= SFRD_ZERO16;
            sbuf_reg          <= SFRD_ZERO8;
            sload_reg         <= 1'b0;
            rdata_reg         <= SFRD_ZERO8;
            rbit_reg          <= 1'b0;
            rvalid_reg        <= 1'b0;
            saddr_reg         <= SFRD_ZERO8;
            swd_reg           <= SFRD_ZERO8;
            swe_reg           <= 1'b0;
            pin_out_reg       <= {SFRD_NPORTS{SFRD_PORT_RESET}};
        end else begin
            port_latch_reg    <= port_latch_next;
            stack_pointer_reg <= stack_pointer_next;
            dptr_reg          <= dptr_next;
            sbuf_reg          <= sbuf_next;
            sload_reg         <= sload_next;
            rdata_reg         <= rdata_next;
            rbit_reg          <= rbit_next;
            rvalid_reg        <= rvalid_next;
            saddr_reg         <= saddr_next;
            swd_reg           <= swd_next;
            swe_reg           <= swe_next;
            pin_out_reg       <= pin_out_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ram_we) begin
            ram_mem[byte_addr[6:0]] <= ram_wval;
        end
        if (swe_next && !saddr_next[7]) begin
            ram_mem[saddr_next[6:0]] <= swd_next;
        end
    end

    assign rdata                 = rdata_reg;
    assign rbit                  = rbit_reg;
    assign rvalid                = rvalid_reg;
    assign port_pin_out          = pin_out_reg;
    assign stack_addr            = saddr_reg;
    assign stack_wdata           = swd_reg;
    assign stack_we              = swe_reg;
    assign data_pointer0         = dptr_reg;
    assign serial_buffer_primary = sbuf_reg;
    assign serial_load           = sload_reg;

    // ******************************
    // checks
    // ******************************
    property p_sp_reset;
        @(posedge sys_clk) $fell(reset) |-> stack_pointer_reg == SFRD_SP_RESET;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("sp not 07 after reset");

    property p_push;
        @(posedge sys_clk) disable iff (reset)
        sp_op == SFRD_SP_PUSH && op == SFRD_OP_NONE
        |=> stack_addr == $past(stack_pointer_reg) + SFRD_ONE8 && stack_we;
    endproperty
    a_push: assert property (p_push) else $error("push address wrong");

    property p_pop;
        @(posedge sys_clk) disable iff (reset)
        sp_op == SFRD_SP_POP && op == SFRD_OP_NONE
        |=> stack_pointer_reg == $past(stack_pointer_reg) - SFRD_ONE8;
    endproperty
    a_pop: assert property (p_pop) else $error("pop did not move sp");

    property p_unassigned;
        @(posedge sys_clk) disable iff (reset)
        op == SFRD_OP_READ && addr[7] && !sfrd_assigned(addr) |=> rdata == SFRD_ZERO8;
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("unassigned read not zero");

    property p_sbuf;
        @(posedge sys_clk) disable iff (reset)
        op == SFRD_OP_WRITE && addr == SFRD_ADDR_SBUF
        |=> serial_load && serial_buffer_primary == $past(wdata);
    endproperty
    a_sbuf: assert property (p_sbuf) else $error("serial buffer not loaded");

    property p_port0;
        @(posedge sys_clk) disable iff (reset)
        op == SFRD_OP_WRITE && addr == SFRD_ADDR_PORT0 && !ext_s2_reg
        |=> ##1 (ext_s2_reg || port_pin_out[7:0] == $past(wdata, 2));
    endproperty
    a_port0: assert property (p_port0) else $error("port 0 pins not driven");

    property p_dptr;
        @(posedge sys_clk) disable iff (reset)
        dptr_inc && op == SFRD_OP_NONE |=> data_pointer0 == $past(dptr_reg) + SFRD_ONE16;
    endproperty
    a_dptr: assert property (p_dptr) else $error("data pointer not 16-bit");

    property p_sp_rw;
        @(posedge sys_clk) disable iff (reset)
        op == SFRD_OP_WRITE && addr == SFRD_ADDR_SP && sp_op == SFRD_SP_HOLD
        ##1 op == SFRD_OP_READ && addr == SFRD_ADDR_SP |=> rdata == $past(wdata, 2);
    endproperty
    a_sp_rw: assert property (p_sp_rw) else $error("write not seen by read");
endmodule // sfrd_space_decoder

// ===== sfrd_far_model.sv
// sfrd_far_model: pins and stack memory seen from outside the decoder
`timescale 1ns/100ps
module sfrd_far_model
    import sfrd_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic [31:0] port_pin_out,
    output logic [31:0]      port_pin_in,
    input  wire logic [7:0]  stack_addr,
    input  wire logic [7:0]  stack_wdata,
    input  wire logic        stack_we
);
    logic [7:0] stack_mem [SFRD_RAM_DEPTH];

    // pins settle to the level port_pin_out drives
    assign port_pin_in = port_pin_out;

    // internal ram bytes written by stack pushes
    always @(posedge sys_clk) begin
        if (stack_we) begin
            stack_mem[stack_addr[6:0]] <= stack_wdata;
        end
    end
endmodule // sfrd_far_model

// ===== sfrd_space_decoder_tb.sv
// sfrd_space_decoder_tb: self-checking bench for the register space decoder
`timescale 1ns/100ps
module sfrd_space_decoder_tb
    import sfrd_pkg::*;
;
    logic        sys_clk, reset, dptr_inc, ext_mem_mode, rbit, rvalid;
    logic        stack_we, serial_load;
    sfrd_op_t    op;
    sfrd_spop_t  sp_op;
    logic [7:0]  addr, wdata, sp_data, rdata, stack_addr, stack_wdata;
    logic [7:0]  serial_buffer_primary;
    logic [15:0] ext_addr, data_pointer0;
    logic [31:0] port_pin_in, port_pin_out;
    int          error_cnt, n_checks, cycles, i;
    logic [7:0]  v;
    logic        b;
    localparam logic [7:0] UNASG [24] = '{8'h96, 8'h97, 8'ha4, 8'hb5, 8'hb6, 8'hb7, 8'hb9,
        8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc7, 8'hc9,
        8'hce, 8'hcf, 8'hf3, 8'hf4, 8'hf5};
    localparam logic [7:0] PORTA [4] = '{SFRD_ADDR_PORT0, SFRD_ADDR_PORT1, SFRD_ADDR_PORT2,
        SFRD_ADDR_PORT3};

    sfrd_space_decoder sfrd_space_decoder_i (.sys_clk(sys_clk), .reset(reset), .op(op),
        .addr(addr), .wdata(wdata), .sp_op(sp_op), .sp_data(sp_data), .dptr_inc(dptr_inc),
        .ext_mem_mode(ext_mem_mode), .ext_addr(ext_addr), .port_pin_in(port_pin_in),
        .rdata(rdata), .rbit(rbit), .rvalid(rvalid), .port_pin_out(port_pin_out),
        .stack_addr(stack_addr), .stack_wdata(stack_wdata), .stack_we(stack_we),
        .data_pointer0(data_pointer0), .serial_buffer_primary(serial_buffer_primary),
        .serial_load(serial_load));
    sfrd_far_model sfrd_far_model_i (.sys_clk(sys_clk), .port_pin_out(port_pin_out),
        .port_pin_in(port_pin_in), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
        .stack_we(stack_we));

    always #2.5 sys_clk = ~sys_clk;

    // ******************************
    // tasks
    // ******************************
    task automatic report_and_stop();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic acc(input sfrd_op_t o, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        op    <= o;
        addr  <= a;
        wdata <= d;
        @(posedge sys_clk);
        op    <= SFRD_OP_NONE;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(SFRD_OP_WRITE, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        acc(SFRD_OP_READ, a, 8'h00);
        #1;
        for (k = 0; k < 4 && rvalid !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
        check(32'(rvalid), 32'h1, "read answer");
        v = rdata;
        b = rbit;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        check(32'(v), 32'(exp), "read data");
    endtask

    task automatic stk(input sfrd_spop_t s, input logic [7:0] d);
        @(posedge sys_clk);
        sp_op   <= s;
        sp_data <= d;
        @(posedge sys_clk);
        sp_op   <= SFRD_SP_HOLD;
        #1;
    endtask

    task automatic settle();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    task automatic inc_dptr();
        @(posedge sys_clk);
        dptr_inc <= 1'b1;
        @(posedge sys_clk);
        dptr_inc <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ******************************
    // main sequence
    // ******************************
    initial begin
        sys_clk = 0; reset = 1; op = SFRD_OP_NONE; addr = 0; wdata = 0; cycles = 0;
        sp_op = SFRD_SP_HOLD; sp_data = 0; dptr_inc = 0; ext_mem_mode = 0; ext_addr = 0;
        error_cnt = 0; n_checks = 0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        rdc(SFRD_ADDR_SP, SFRD_SP_RESET);
        rdc(SFRD_ADDR_PORT0, SFRD_PORT_RESET);
        wr(8'h7f, 8'h3c);
        wr(SFRD_ADDR_PORT0, 8'hc3);
        rdc(8'h7f, 8'h3c);
        settle();
        rdc(SFRD_ADDR_PORT0, 8'hc3);
        for (i = 0; i < 24; i++) begin
            wr(UNASG[i], 8'hff);
            rdc(UNASG[i], 8'h00);
        end
        rdc(SFRD_ADDR_SP, SFRD_SP_RESET);
        check(32'(serial_buffer_primary), 32'h0, "buffer untouched");
        wr(SFRD_ADDR_SBUF, 8'h24);
        #1;
        check(32'(serial_load), 32'h1, "load pulse");
        check(32'(serial_buffer_primary), 32'h24, "buffer");
        @(posedge sys_clk);
        #1;
        check(32'(serial_load), 32'h0, "load pulse end");
        for (i = 0; i < 4; i++) wr(PORTA[i], 8'ha5 ^ 8'(i));
        settle();
        for (i = 0; i < 4; i++) begin
            check(32'(port_pin_out[8*i+:8]), 32'(8'ha5 ^ 8'(i)), "pins");
            rdc(PORTA[i], 8'ha5 ^ 8'(i));
        end
        for (i = 0; i < 4; i++) begin
            wr(PORTA[i], 8'h00);
            acc(SFRD_OP_BSET, PORTA[i] + 8'h07, 8'h00);
            acc(SFRD_OP_BSET, PORTA[i], 8'h00);
            settle();
            check(32'(port_pin_out[8*i+:8]), 32'h81, "bit set");
            acc(SFRD_OP_BCLR, PORTA[i] + 8'h07, 8'h00);
            settle();
            check(32'(port_pin_out[8*i+:8]), 32'h01, "bit clear");
        end
        acc(SFRD_OP_BSET, SFRD_ADDR_SP, 8'h00);
        settle();
        check(32'(port_pin_out[7:0]), 32'h03, "bit op off base");
        rdc(SFRD_ADDR_SP, SFRD_SP_RESET);
        wr(8'h21, 8'h01);
        rd(8'h08);
        check(32'(b), 32'h1, "ram bit");
        acc(SFRD_OP_BSET, 8'h0f, 8'h00);
        rdc(8'h21, 8'h81);
        stk(SFRD_SP_PUSH, 8'h5a);
        check(32'(stack_we), 32'h1, "push strobe");
        check(32'(stack_addr), 32'h08, "first push");
        stk(SFRD_SP_CALL, 8'h66);
        check(32'(stack_addr), 32'h09, "call push");
        rdc(SFRD_ADDR_SP, 8'h09);
        check(32'(sfrd_far_model_i.stack_mem[7'h08]), 32'h5a, "stack byte");
        stk(SFRD_SP_POP, 8'h00);
        stk(SFRD_SP_RET, 8'h00);
        rdc(SFRD_ADDR_SP, SFRD_SP_RESET);
        wr(SFRD_ADDR_SP, 8'h2f);
        stk(SFRD_SP_PUSH, 8'h77);
        check(32'(stack_addr), 32'h30, "push above 2f");
        check(32'(stack_wdata), 32'h77, "push data");
        // write then read back to back, no idle cycle between
        @(posedge sys_clk);
        op    <= SFRD_OP_WRITE;
        addr  <= SFRD_ADDR_SP;
        wdata <= 8'h3e;
        @(posedge sys_clk);
        op    <= SFRD_OP_READ;
        @(posedge sys_clk);
        op    <= SFRD_OP_NONE;
        #1;
        check(32'(rdata), 32'h3e, "write then read");
        wr(SFRD_ADDR_DATA_POINTER0_LOW, 8'hff);
        wr(SFRD_ADDR_DATA_POINTER0_HIGH, 8'h12);
        @(posedge sys_clk);
        #1;
        check(32'(data_pointer0), 32'h12ff, "pointer pair");
        inc_dptr();
        check(32'(data_pointer0), 32'h1300, "pointer carry");
        rdc(SFRD_ADDR_DATA_POINTER0_LOW, 8'h00);
        rdc(SFRD_ADDR_DATA_POINTER0_HIGH, 8'h13);
        wr(SFRD_ADDR_DATA_POINTER0_HIGH, 8'hff);
        wr(SFRD_ADDR_DATA_POINTER0_LOW, 8'hff);
        inc_dptr();
        check(32'(data_pointer0), 32'h0000, "pointer wrap");
        @(posedge sys_clk);
        ext_addr     <= 16'h5aa5;
        ext_mem_mode <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        check(32'(port_pin_out[7:0]), 32'ha5, "ext low");
        check(32'(port_pin_out[23:16]), 32'h5a, "ext high");
        check(32'(port_pin_out[15:8]), 32'h01, "port1 kept");
        @(posedge sys_clk);
        ext_mem_mode <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        check(32'(port_pin_out[7:0]), 32'h03, "port0 back");
        report_and_stop();
    end
endmodule // sfrd_space_decoder_tb
